// File: sio_sysmod_ctrl.sv
// System module end: AXI4-Lite registers driving the serial link to the shelf.
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "sio_consts.svh"
`default_nettype none
module sio_sysmod_ctrl #(
   parameter int HALF_CYCLES = `SIO_HALF_CYCLES,
   parameter int FAN_START_CYCLES = `SIO_FAN_START_S * `SIO_CLK_HZ,
   parameter int FLASH_CYCLES = `SIO_FLASH_MS * (`SIO_CLK_HZ / 1000)
) (
   sio_link_if.ctrl link,
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic reflected_power_sense
);
   sio_pkg::sio_state_t st_q;
   sio_pkg::sio_op_t op_q;
   sio_pkg::sio_op_t cmd_op_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_have_q;
   logic w_have_q;
   logic [1:0] ctrl_q;
   logic [7:0] out_q;
   logic [7:0] sent_q;
   logic [7:0] eff;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic cmd_pend_q;
   logic cmd_sel_q;
   logic cmd_dir_q;
   logic [7:0] cmd_cnt_q;
   logic dir_q;
   logic [2:0] addr_q;
   logic [8:0] pidx_q;
   logic [8:0] total_q;
   logic [31:0] tmr_q;
   logic [31:0] fan_tmr_q;
   logic [31:0] flash_tmr_q;
   logic fan_boost_q;
   logic flash_q;
   logic lockout_q;
   logic [1:0] ret_s_q;
   logic [1:0] refl_s_q;
   logic wr_go;
   logic half_done;

   assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   assign half_done = tmr_q == 32'(HALF_CYCLES - 1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ret_s_q <= 2'b11;
         refl_s_q <= 2'b00;
      end else begin
         ret_s_q <= {ret_s_q[0], link.flag_return_line};
         refl_s_q <= {refl_s_q[0], reflected_power_sense};
      end
   end

   // One write at a time: both readies reopen only after the response is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SIO_RESP_OKAY;
         awaddr_q <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q == `SIO_REG_CTRL || awaddr_q == `SIO_REG_OUT ||
                            awaddr_q == `SIO_REG_CMD) ? `SIO_RESP_OKAY : `SIO_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= 2'b00;
         out_q <= 8'h00;
      end else if (wr_go && wstrb_q[0]) begin
         if (awaddr_q == `SIO_REG_CTRL) begin
            ctrl_q <= wdata_q[1:0];
         end else if (awaddr_q == `SIO_REG_OUT) begin
            out_q <= wdata_q[7:0];
         end
      end
   end

   // A command arriving while one is pending or running is dropped.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_pend_q <= 1'b0;
         cmd_op_q <= sio_pkg::SIO_OP_NONE;
         cmd_sel_q <= 1'b0;
         cmd_dir_q <= 1'b0;
         cmd_cnt_q <= 8'h00;
      end else if (wr_go && wstrb_q[1:0] == 2'b11 && awaddr_q == `SIO_REG_CMD &&
                   !cmd_pend_q && st_q == sio_pkg::SIO_ST_IDLE) begin
         cmd_pend_q <= wdata_q[1:0] == 2'b01 || (wdata_q[1:0] == 2'b10 && wdata_q[15:8] != 8'h00);
         cmd_op_q <= sio_pkg::sio_op_t'(wdata_q[1:0]);
         cmd_sel_q <= wdata_q[2];
         cmd_dir_q <= wdata_q[3];
         cmd_cnt_q <= wdata_q[15:8];
      end else if (st_q == sio_pkg::SIO_ST_IDLE && eff == sent_q) begin
         cmd_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SIO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `SIO_RESP_OKAY;
         if (s_axi_araddr == `SIO_REG_CTRL) begin
            s_axi_rdata <= {30'h0000_0000, ctrl_q};
         end else if (s_axi_araddr == `SIO_REG_OUT) begin
            s_axi_rdata <= {24'h00_0000, out_q};
         end else if (s_axi_araddr == `SIO_REG_STATUS) begin
            s_axi_rdata <= {8'h00, sent_q, rx_q, 5'h00, lockout_q, cmd_pend_q,
                            st_q != sio_pkg::SIO_ST_IDLE};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SIO_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fan_tmr_q <= 32'h0000_0000;
         fan_boost_q <= 1'b1;
         flash_tmr_q <= 32'h0000_0000;
         flash_q <= 1'b0;
         lockout_q <= 1'b0;
      end else begin
         if (fan_boost_q) begin
            fan_tmr_q <= fan_tmr_q + 1'b1;
            fan_boost_q <= fan_tmr_q != 32'(FAN_START_CYCLES - 1);
         end
         flash_tmr_q <= (flash_tmr_q == 32'(FLASH_CYCLES - 1)) ? 32'h0000_0000
                        : flash_tmr_q + 1'b1;
         if (flash_tmr_q == 32'(FLASH_CYCLES - 1)) begin
            flash_q <= !flash_q;
         end
         // Only a reset releases the lockout.
         if (ctrl_q[0] && refl_s_q[1]) begin
            lockout_q <= 1'b1;
         end
      end
   end

   // The byte to show always carries the fan bits and the lamp; any change is resent.
   always_comb begin
      eff = out_q;
      eff[`SIO_BIT_FAN_RUN] = 1'b1;
      eff[`SIO_BIT_FAN_START] = fan_boost_q;
      eff[`SIO_BIT_LAMP] = lockout_q ? flash_q : out_q[`SIO_BIT_LAMP];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= sio_pkg::SIO_ST_IDLE;
         op_q <= sio_pkg::SIO_OP_NONE;
         sent_q <= 8'h00;
         tx_q <= 8'h00;
         rx_q <= 8'h00;
         dir_q <= 1'b0;
         addr_q <= 3'h0;
         pidx_q <= 9'h000;
         total_q <= 9'h000;
         tmr_q <= 32'h0000_0000;
      end else begin
         case (st_q)
            sio_pkg::SIO_ST_IDLE: begin
               tmr_q <= 32'h0000_0000;
               pidx_q <= 9'h000;
               if (eff != sent_q) begin
                  op_q <= sio_pkg::SIO_OP_WRITE;
                  addr_q <= `SIO_ADDR_OUT;
                  tx_q <= eff;
                  sent_q <= eff;
                  total_q <= 9'h009;
                  st_q <= sio_pkg::SIO_ST_LOW;
               end else if (cmd_pend_q) begin
                  op_q <= cmd_op_q;
                  dir_q <= cmd_dir_q;
                  if (cmd_op_q == sio_pkg::SIO_OP_READ) begin
                     addr_q <= `SIO_ADDR_FLAG;
                     total_q <= 9'h009;
                  end else begin
                     addr_q <= cmd_sel_q ? `SIO_ADDR_SQ_POT : `SIO_ADDR_PWR_POT;
                     total_q <= {1'b0, cmd_cnt_q};
                  end
                  st_q <= sio_pkg::SIO_ST_LOW;
               end
            end
            sio_pkg::SIO_ST_LOW: begin
               tmr_q <= half_done ? 32'h0000_0000 : tmr_q + 1'b1;
               if (half_done) begin
                  if (op_q == sio_pkg::SIO_OP_READ && pidx_q != 9'h000) begin
                     rx_q <= {ret_s_q[1], rx_q[7:1]};
                  end
                  st_q <= sio_pkg::SIO_ST_HIGH;
               end
            end
            sio_pkg::SIO_ST_HIGH: begin
               tmr_q <= half_done ? 32'h0000_0000 : tmr_q + 1'b1;
               if (half_done) begin
                  tx_q <= {tx_q[6:0], 1'b0};
                  pidx_q <= pidx_q + 1'b1;
                  st_q <= (pidx_q + 1'b1 == total_q) ? sio_pkg::SIO_ST_IDLE
                          : sio_pkg::SIO_ST_LOW;
               end
            end
            default: begin
               st_q <= sio_pkg::SIO_ST_IDLE;
            end
         endcase
      end
   end

   // Select, strobe and data settle while the link clock is low.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link.select_bit2 <= 1'b0;
         link.select_bit1 <= 1'b0;
         link.select_bit0 <= 1'b0;
         link.strobe_line <= 1'b0;
         link.expander_data_line <= 1'b0;
         link.serial_clock <= 1'b0;
         link.first_relay_drive <= 1'b0;
         link.amplifier_key <= 1'b0;
      end else begin
         link.first_relay_drive <= ctrl_q[1];
         link.amplifier_key <= ctrl_q[0] && !lockout_q && !refl_s_q[1];
         link.serial_clock <= st_q == sio_pkg::SIO_ST_HIGH;
         if (st_q == sio_pkg::SIO_ST_LOW) begin
            {link.select_bit2, link.select_bit1, link.select_bit0} <= addr_q;
            link.expander_data_line <= tx_q[7];
            if (op_q == sio_pkg::SIO_OP_READ) begin
               link.strobe_line <= pidx_q == 9'h000;
            end else if (op_q == sio_pkg::SIO_OP_WRITE) begin
               link.strobe_line <= pidx_q == 9'h008;
            end else begin
               link.strobe_line <= dir_q;
            end
         end else if (st_q == sio_pkg::SIO_ST_IDLE) begin
            link.strobe_line <= 1'b0;
         end
      end
   end
endmodule : sio_sysmod_ctrl
`default_nettype wire

// File: sio_consts.svh
// Constants for the shelf I/O expander link, its two ends and the register map.
// Function
// - Negative current above 2 mA drives polarity low.
// - Magnitude above 6 mA drives mid-level low.
// - Magnitude above 11 mA drives high-level low.
// - Detects active low; high implies mid.
// - Controller sets select lines before each transaction.
// - Strobe high plus one pulse loads flags.
// - Strobe low pulses shift flags out LSB first.
// - Three don't-care bits, then flag 4..0.
// - Five module flags, amplifier fault is flag 4.
// - Data bit sampled on clock leading edge.
// - Strobe high pulse moves buffer to latch.
// - Controller sends output byte MSB first.
// - Latch bits: lamp, fan start, fan run, reference.
// - Latch bit 4 drives second auxiliary relay.
// - Fans both on, start cleared after 10 s.
// - Controller addresses potentiometer before stepping it.
// - Strobe picks direction, each pulse one step.
// - Squelch pot alike; remote mode ignores manual.
// - Reflected power fault unkeys, flashes, locks until reset.
// - Dedicated line drives first auxiliary relay.
// - Squelch relay follows receiver mute.
// - Amplifier key passes straight to the amplifier.
`ifndef SIO_CONSTS_SVH
`define SIO_CONSTS_SVH
`define SIO_ADDR_FLAG 3'h1
`define SIO_ADDR_OUT 3'h2
`define SIO_ADDR_PWR_POT 3'h3
`define SIO_ADDR_SQ_POT 3'h4
`define SIO_NEG_THR_HALF_MA 4
`define SIO_MID_THR_HALF_MA 12
`define SIO_HIGH_THR_HALF_MA 22
`define SIO_BIT_LAMP 3
`define SIO_BIT_FAN_START 2
`define SIO_BIT_FAN_RUN 1
`define SIO_BIT_REF 0
`define SIO_BIT_RELAY2 4
`define SIO_POT_RESET 0
`define SIO_CLK_HZ 50000000
`define SIO_FAN_START_S 10
`define SIO_FLASH_MS 250
`define SIO_HALF_CYCLES 4
`define SIO_REG_CTRL 32'h0000_0000
`define SIO_REG_OUT 32'h0000_0004
`define SIO_REG_CMD 32'h0000_0008
`define SIO_REG_STATUS 32'h0000_000C
`define SIO_RESP_OKAY 2'h0
`define SIO_RESP_SLVERR 2'h2
`endif

// File: sio_pkg.sv
// Types used by the system module end of the shelf I/O link.
`default_nettype none
package sio_pkg;
   typedef enum logic [1:0] {
      SIO_ST_IDLE = 2'b00,
      SIO_ST_LOW = 2'b01,
      SIO_ST_HIGH = 2'b10
   } sio_state_t;
   typedef enum logic [1:0] {
      SIO_OP_NONE = 2'b00,
      SIO_OP_READ = 2'b01,
      SIO_OP_POT = 2'b10,
      SIO_OP_WRITE = 2'b11
   } sio_op_t;
endpackage : sio_pkg
`default_nettype wire

// File: sio_link_if.sv
// Serial link between the system module controller and the shelf interface board.
`default_nettype none
interface sio_link_if;
   logic select_bit2;
   logic select_bit1;
   logic select_bit0;
   logic strobe_line;
   logic serial_clock;
   logic expander_data_line;
   logic first_relay_drive;
   logic amplifier_key;
   logic flag_return_out;
   logic flag_return_oe_n;
   logic flag_return_line;
   // An undriven return line floats high through its pull-up.
   assign flag_return_line = flag_return_oe_n ? 1'b1 : flag_return_out;
   modport device (
      input select_bit2, select_bit1, select_bit0, strobe_line, serial_clock,
      input expander_data_line, first_relay_drive, amplifier_key,
      output flag_return_out, flag_return_oe_n
   );
   modport ctrl (
      output select_bit2, select_bit1, select_bit0, strobe_line, serial_clock,
      output expander_data_line, first_relay_drive, amplifier_key,
      input flag_return_line
   );
endinterface : sio_link_if
`default_nettype wire

// File: sio_shelf_dev.sv
// Interface board end: flag register, output register, potentiometers, current decode.
`include "sio_consts.svh"
`default_nettype none
module sio_shelf_dev #(
   parameter int POT_W = 7,
   parameter int CUR_W = 8
) (
   sio_link_if.device link,
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [4:0] module_flags,
   input wire logic receiver_mute,
   input wire logic remote_squelch_select,
   input wire logic [POT_W-1:0] manual_squelch_level,
   input wire logic signed [CUR_W-1:0] control_current_half_ma,
   output logic negative_polarity_detect_n,
   output logic mid_level_current_detect_n,
   output logic high_level_current_detect_n,
   output logic amplifier_fault_lamp,
   output logic fan_start,
   output logic fan_run,
   output logic reference_source_select,
   output logic first_relay,
   output logic second_relay,
   output logic squelch_relay,
   output logic transmit_oscillator_control,
   output logic [POT_W-1:0] amplifier_power_level,
   output logic [POT_W-1:0] squelch_level_out
);
   localparam int SW = 8 + 5 + 2 + POT_W + CUR_W;
   localparam logic [POT_W-1:0] POT_MAX = {POT_W{1'b1}};
   localparam logic [POT_W-1:0] POT_RST = POT_W'(`SIO_POT_RESET);
   localparam logic signed [CUR_W:0] NEG_THR = (CUR_W+1)'(`SIO_NEG_THR_HALF_MA);
   localparam logic signed [CUR_W:0] MID_THR = (CUR_W+1)'(`SIO_MID_THR_HALF_MA);
   localparam logic signed [CUR_W:0] HIGH_THR = (CUR_W+1)'(`SIO_HIGH_THR_HALF_MA);

   logic [SW-1:0] raw;
   logic [SW-1:0] s1_q;
   logic [SW-1:0] s2_q;
   logic [2:0] sel;
   logic strobe;
   logic sclk;
   logic data_in;
   logic relay1_in;
   logic key_in;
   logic [4:0] flags_in;
   logic mute_in;
   logic remote_in;
   logic [POT_W-1:0] manual_in;
   logic signed [CUR_W-1:0] cur_in;
   logic sclk_prev_q;
   logic rise;
   logic signed [CUR_W:0] cur_ext;
   logic signed [CUR_W:0] mag;
   logic [7:0] flag_q;
   logic [7:0] buf_q;
   logic [7:0] latch_q;
   logic [POT_W-1:0] pot_q [2];
   logic [2:0] pot_addr [2];
   logic ret_out_q;
   logic ret_oe_n_q;

   assign raw = {link.select_bit2, link.select_bit1, link.select_bit0,
                 link.strobe_line, link.serial_clock, link.expander_data_line,
                 link.first_relay_drive, link.amplifier_key, module_flags,
                 receiver_mute, remote_squelch_select, manual_squelch_level,
                 control_current_half_ma};

   // Every pin is resynchronised; the link clock is only sampled, never used as a clock.
   genvar gi;
   generate
      for (gi = 0; gi < SW; gi++) begin : g_sync
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= raw[gi];
               s2_q[gi] <= s1_q[gi];
            end
         end
      end
   endgenerate

   assign sel = s2_q[SW-1 -: 3];
   assign strobe = s2_q[SW-4];
   assign sclk = s2_q[SW-5];
   assign data_in = s2_q[SW-6];
   assign relay1_in = s2_q[SW-7];
   assign key_in = s2_q[SW-8];
   assign flags_in = s2_q[SW-9 -: 5];
   assign mute_in = s2_q[POT_W+CUR_W+1];
   assign remote_in = s2_q[POT_W+CUR_W];
   assign manual_in = s2_q[CUR_W +: POT_W];
   assign cur_in = s2_q[CUR_W-1:0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk;
      end
   end

   // Work is done on the leading edge of each link clock pulse.
   assign rise = sclk && !sclk_prev_q;

   assign cur_ext = {cur_in[CUR_W-1], cur_in};
   assign mag = cur_ext[CUR_W] ? -cur_ext : cur_ext;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         negative_polarity_detect_n <= 1'b1;
         mid_level_current_detect_n <= 1'b1;
         high_level_current_detect_n <= 1'b1;
      end else begin
         negative_polarity_detect_n <= !(cur_ext < -NEG_THR);
         // Testing both thresholds keeps mid asserted whenever high is.
         // A current right at the mid or high threshold already counts as detected.
         mid_level_current_detect_n <= !(mag >= MID_THR || mag >= HIGH_THR);
         high_level_current_detect_n <= !(mag >= HIGH_THR);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= 8'h00;
      end else if (rise && sel == `SIO_ADDR_FLAG) begin
         if (strobe) begin
            // Flag 4 sits fourth out, flag 0 eighth; the low three are padding.
            flag_q <= {flags_in[0], flags_in[1], flags_in[2], flags_in[3],
                       flags_in[4], 3'b000};
         end else begin
            flag_q <= {1'b0, flag_q[7:1]};
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ret_out_q <= 1'b1;
         ret_oe_n_q <= 1'b1;
      end else begin
         ret_out_q <= flag_q[0];
         ret_oe_n_q <= sel != `SIO_ADDR_FLAG;
      end
   end

   assign link.flag_return_out = ret_out_q;
   assign link.flag_return_oe_n = ret_oe_n_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         buf_q <= 8'h00;
      end else if (rise && sel == `SIO_ADDR_OUT && !strobe) begin
         buf_q <= {buf_q[6:0], data_in};
      end
   end

   // The latch only changes on a strobed pulse, so shifting never glitches outputs.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_q <= 8'h00;
      end else if (rise && sel == `SIO_ADDR_OUT && strobe) begin
         latch_q <= buf_q;
      end
   end

   assign pot_addr[0] = `SIO_ADDR_PWR_POT;
   assign pot_addr[1] = `SIO_ADDR_SQ_POT;

   // Both potentiometers share one step protocol and saturate at their ends.
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pot
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               pot_q[gi] <= POT_RST;
            end else if (rise && sel == pot_addr[gi]) begin
               if (strobe && pot_q[gi] != POT_MAX) begin
                  pot_q[gi] <= pot_q[gi] + 1'b1;
               end else if (!strobe && pot_q[gi] != '0) begin
                  pot_q[gi] <= pot_q[gi] - 1'b1;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         amplifier_fault_lamp <= 1'b0;
         fan_start <= 1'b0;
         fan_run <= 1'b0;
         reference_source_select <= 1'b0;
         second_relay <= 1'b0;
      end else begin
         amplifier_fault_lamp <= latch_q[`SIO_BIT_LAMP];
         fan_start <= latch_q[`SIO_BIT_FAN_START];
         fan_run <= latch_q[`SIO_BIT_FAN_RUN];
         reference_source_select <= latch_q[`SIO_BIT_REF];
         second_relay <= latch_q[`SIO_BIT_RELAY2];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_relay <= 1'b0;
         squelch_relay <= 1'b0;
         transmit_oscillator_control <= 1'b0;
      end else begin
         first_relay <= relay1_in;
         squelch_relay <= mute_in;
         transmit_oscillator_control <= key_in;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         amplifier_power_level <= POT_RST;
         squelch_level_out <= '0;
      end else begin
         amplifier_power_level <= pot_q[0];
         // Remote mode cuts the manual control out entirely.
         squelch_level_out <= remote_in ? pot_q[1] : manual_in;
      end
   end
endmodule : sio_shelf_dev
`default_nettype wire

// File: sio_props.sv
// Link checker for the shelf I/O serial link.
`include "sio_consts.svh"
`default_nettype none
module sio_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic select_bit2,
   input wire logic select_bit1,
   input wire logic select_bit0,
   input wire logic strobe_line,
   input wire logic serial_clock,
   input wire logic expander_data_line,
   input wire logic flag_return_oe_n
);
   wire [2:0] sel = {select_bit2, select_bit1, select_bit0};
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sel_held_a: assert property (serial_clock |-> $stable(sel)) else $error("select moved");
   data_held_a: assert property (serial_clock |-> $stable(expander_data_line))
      else $error("data moved");
   dir_held_a: assert property (serial_clock |-> $stable(strobe_line))
      else $error("strobe moved");
   high_phase_a: assert property ($rose(serial_clock) |->
      serial_clock[*4] ##1 !serial_clock) else $error("bad high phase");
   low_phase_a: assert property ($fell(serial_clock) |-> !serial_clock[*4])
      else $error("bad low phase");
   return_owner_a: assert property ($fell(serial_clock) && !flag_return_oe_n
      |-> sel == `SIO_ADDR_FLAG) else $error("return driven unselected");
   load_drive_a: assert property ($rose(serial_clock) && strobe_line
      && sel == `SIO_ADDR_FLAG |-> ##[1:8] !flag_return_oe_n) else $error("flag load not driven");
   return_free_a: assert property ($rose(serial_clock) && sel != `SIO_ADDR_FLAG
      |-> ##[0:4] flag_return_oe_n) else $error("return not released");
   cover property ($rose(serial_clock) && strobe_line && sel == `SIO_ADDR_FLAG);
   cover property ($rose(serial_clock) && strobe_line && sel == `SIO_ADDR_OUT);
   cover property ($rose(serial_clock) && sel == `SIO_ADDR_SQ_POT);
endmodule : sio_props
`default_nettype wire

// File: sio_testbench.sv
// Testbench joining both link ends and driving the controller over AXI4-Lite.
`include "sio_consts.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, v;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, receiver_mute = 1'b0, remote_squelch_select = 1'b1;
   logic reflected_power_sense = 1'b0, negative_polarity_detect_n, mid_level_current_detect_n;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [4:0] module_flags = 5'h16;
   logic [6:0] manual_squelch_level = 7'h55, amplifier_power_level, squelch_level_out;
   logic signed [7:0] control_current_half_ma = '0;
   logic high_level_current_detect_n, amplifier_fault_lamp, fan_start, fan_run, first_relay;
   logic reference_source_select, second_relay, squelch_relay, transmit_oscillator_control;
   logic [7:0] cur [9] = '{8'h00, 8'he9, 8'h17, 8'hfb, 8'hf3, 8'h0d, 8'hfc, 8'h0c, 8'h16};
   logic [2:0] dec [9] = '{3'h7, 3'h0, 3'h1, 3'h6, 3'h4, 3'h5, 3'h7, 3'h5, 3'h1};
   int bad_count = 0, checked = 0;
   wire [4:0] lat = {second_relay, amplifier_fault_lamp, fan_start, fan_run,
      reference_source_select};
   sio_link_if lnk ();
   sio_shelf_dev i_sio_shelf_dev (.link(lnk), .*);
   // Shortened fan and flash counts keep the run brief.
   sio_sysmod_ctrl #(.FAN_START_CYCLES(200), .FLASH_CYCLES(50)) i_sio_sysmod_ctrl (.link(lnk), .*);
   sio_props i_sio_props (.aclk, .aresetn, .select_bit2(lnk.select_bit2),
      .select_bit1(lnk.select_bit1), .select_bit0(lnk.select_bit0),
      .strobe_line(lnk.strobe_line), .serial_clock(lnk.serial_clock),
      .expander_data_line(lnk.expander_data_line), .flag_return_oe_n(lnk.flag_return_oe_n));
   initial forever #10 aclk = ~aclk;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [31:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   // Waits until the link has gone quiet; the last status word stays in v.
   task automatic idle();
      repeat (4) @(posedge aclk);
      do rd(`SIO_REG_STATUS); while (v[1:0] !== 2'b00);
      repeat (8) @(posedge aclk);
   endtask : idle
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   initial begin
      #400us;
      bad_count++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      idle();
      chk("fans start", 32'h3, {fan_start, fan_run});
      repeat (200) @(posedge aclk);
      idle();
      chk("fans run", 32'h1, {fan_start, fan_run});
      foreach (cur[i]) begin
         control_current_half_ma <= cur[i];
         repeat (6) @(posedge aclk);
         chk("decode", dec[i], {high_level_current_detect_n, mid_level_current_detect_n,
            negative_polarity_detect_n});
      end
      wr(`SIO_REG_OUT, 32'h19);
      idle();
      chk("latch", 32'h1b, lat);
      chk("sent", 32'h1b, v[23:16]);
      wr(`SIO_REG_OUT, 32'h0);
      idle();
      chk("latch clr", 32'h2, lat);
      wr(`SIO_REG_CMD, 32'h1);
      idle();
      chk("flags", 32'h68, v[15:8]);
      wr(`SIO_REG_CMD, 32'h050a);
      idle();
      wr(`SIO_REG_CMD, 32'h0202);
      idle();
      wr(`SIO_REG_CMD, 32'h040e);
      idle();
      chk("power pot", 32'h3, amplifier_power_level);
      chk("squelch pot", 32'h4, squelch_level_out);
      remote_squelch_select <= 1'b0;
      wr(`SIO_REG_CTRL, 32'h3);
      receiver_mute <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("manual", 32'h55, squelch_level_out);
      chk("key relay mute", 32'h7,
         {transmit_oscillator_control, first_relay, squelch_relay});
      reflected_power_sense <= 1'b1;
      repeat (10) @(posedge aclk);
      rd(`SIO_REG_STATUS);
      chk("lockout", 32'h2, {v[2], transmit_oscillator_control});
      wr(`SIO_REG_CTRL, 32'h0);
      repeat (6) @(posedge aclk);
      chk("relay off", 32'h0, first_relay);
      wr(32'h40, 32'h0);
      chk("wr unmapped", `SIO_RESP_SLVERR, r);
      rd(32'h40);
      chk("rd unmapped", `SIO_RESP_SLVERR, r);
      summarize();
   end
endmodule : testbench
`default_nettype wire
